// *** logic/cif_pkg.sv ***
/*
  package for the codec event-flag and first interrupt line block:
  register indices, field positions, reset values, timing and types.
  assumes a 20 MHz core clock and a 32-bit apb slave port.
*/
`default_nettype none
package cif_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_DAC_STICKY = 6'h2c;
  localparam logic [5:0] IDX_REC_FIRST = 6'h2d;
  localparam logic [5:0] IDX_PLAYBACK = 6'h2e;
  localparam logic [5:0] IDX_REC_SECOND = 6'h2f;
  localparam logic [5:0] IDX_IRQ1_CTRL = 6'h30;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------
  // playback flag fields
  // ----------------------------------------------------------------
  localparam int PB_SHORT = 7;
  localparam int PB_BUTTON = 5;
  localparam int PB_HEADSET = 4;
  localparam int PB_DRC_LEFT = 3;
  localparam int PB_DRC_RIGHT = 2;
  localparam int PB_ENG_STD = 1;
  localparam int PB_ENG_AUX = 0;

  // ----------------------------------------------------------------
  // record flag fields (both record registers)
  // ----------------------------------------------------------------
  localparam int RC_NOISE = 6;
  localparam int RC_ENG_STD = 4;
  localparam int RC_ENG_AUX = 3;
  localparam int RC_DC_AVAIL = 2;

  // ----------------------------------------------------------------
  // first interrupt line control fields
  // ----------------------------------------------------------------
  localparam int EN_HEADSET = 7;
  localparam int EN_BUTTON = 6;
  localparam int EN_DRC = 5;
  localparam int EN_AGC = 4;
  localparam int EN_SHORT = 3;
  localparam int EN_ENGINE = 2;
  localparam int EN_DC = 1;
  localparam int MODE_REPEAT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int PULSE_MS = 2;
  localparam int PERIOD_MS = 4;
  localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
  localparam int PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
  localparam int CNT_W = 17;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic short_det;
    logic button;
    logic headset_in;
    logic drc_left;
    logic drc_right;
    logic pb_eng_std;
    logic pb_eng_aux;
    logic agc_noise;
    logic agc_noise_mono;
    logic rec_eng_std;
    logic rec_eng_aux;
    logic dc_avail;
  } cif_src_t;

  typedef enum logic [1:0] {
    CIF_IDLE = 2'b00,
    CIF_HIGH = 2'b01,
    CIF_LOW = 2'b11
  } cif_state_t;
endpackage
`default_nettype wire

// *** logic/cif_irq_flags.sv ***
/*
  event flag registers and first interrupt line pulse generator of an
  audio codec, with an apb register port.
  assumes event sources are synchronous to core_clk_i and that the host
  answers repeated pulses by reading both sticky flag registers.
*/
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module cif_irq_flags #(
  parameter int ADDR_W = 8,
  parameter int PULSE_CYC = cif_pkg::PULSE_CYC,
  parameter int PERIOD_CYC = cif_pkg::PERIOD_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire cif_pkg::cif_src_t src_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_line_one_o
);
  // ----------------------------------------------------------------
  // event flag capture
  // ----------------------------------------------------------------
  logic [7:0] pb_q;
  logic [7:0] rec1_q;
  logic [7:0] rec2_q;
  logic [7:0] ctrl_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pb_q <= cif_pkg::FLAG_RESET;
    end else begin
      pb_q <= 8'h00;
      pb_q[cif_pkg::PB_SHORT] <= src_i.short_det;
      pb_q[cif_pkg::PB_BUTTON] <= src_i.button;
      pb_q[cif_pkg::PB_HEADSET] <= src_i.headset_in;
      pb_q[cif_pkg::PB_DRC_LEFT] <= src_i.drc_left;
      pb_q[cif_pkg::PB_DRC_RIGHT] <= src_i.drc_right;
      pb_q[cif_pkg::PB_ENG_STD] <= src_i.pb_eng_std;
      pb_q[cif_pkg::PB_ENG_AUX] <= src_i.pb_eng_aux;
    end
  end

  // reserved positions are cleared every cycle, so they stay zero
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rec1_q <= cif_pkg::FLAG_RESET;
      rec2_q <= cif_pkg::FLAG_RESET;
    end else begin
      rec1_q <= 8'h00;
      rec2_q <= 8'h00;
      rec1_q[cif_pkg::RC_NOISE] <= src_i.agc_noise;
      rec1_q[cif_pkg::RC_ENG_STD] <= src_i.rec_eng_std;
      rec1_q[cif_pkg::RC_ENG_AUX] <= src_i.rec_eng_aux;
      rec1_q[cif_pkg::RC_DC_AVAIL] <= src_i.dc_avail;
      rec2_q[cif_pkg::RC_NOISE] <= src_i.agc_noise_mono;
      rec2_q[cif_pkg::RC_ENG_STD] <= src_i.rec_eng_std;
      rec2_q[cif_pkg::RC_ENG_AUX] <= src_i.rec_eng_aux;
      rec2_q[cif_pkg::RC_DC_AVAIL] <= src_i.dc_avail;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_w;
  logic access_w;
  logic aligned_w;
  localparam int ADDR_LSB_W = cif_pkg::ADDR_LSB;
  logic [ADDR_W-ADDR_LSB_W-1:0] idx_w;
  logic hit_w;

  assign setup_w = psel_i && !penable_i;
  assign access_w = psel_i && penable_i;
  assign aligned_w = (paddr_i[ADDR_LSB_W-1:0] == '0);
  assign idx_w = paddr_i[ADDR_W-1:ADDR_LSB_W];

  always_comb begin
    hit_w = 1'b0;
    if (aligned_w) begin
      case (6'(idx_w))
        cif_pkg::IDX_DAC_STICKY,
        cif_pkg::IDX_REC_FIRST,
        cif_pkg::IDX_PLAYBACK,
        cif_pkg::IDX_REC_SECOND,
        cif_pkg::IDX_IRQ1_CTRL: hit_w = 1'b1;
        default: hit_w = 1'b0;
      endcase
    end
  end

  // zero wait states: read data is loaded during the setup cycle
  assign pready_o = 1'b1;
  assign pslverr_o = access_w && !hit_w;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_o <= 32'h0000_0000;
      if (aligned_w && !pwrite_i) begin
        case (6'(idx_w))
          cif_pkg::IDX_REC_FIRST: prdata_o[7:0] <= rec1_q;
          cif_pkg::IDX_PLAYBACK: prdata_o[7:0] <= pb_q;
          cif_pkg::IDX_REC_SECOND: prdata_o[7:0] <= rec2_q;
          cif_pkg::IDX_IRQ1_CTRL: prdata_o[7:0] <= ctrl_q;
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= cif_pkg::CTRL_RESET;
    end else if (access_w && pwrite_i && pstrb_i[0] && aligned_w
                 && 6'(idx_w) == cif_pkg::IDX_IRQ1_CTRL) begin
      ctrl_q <= pwdata_i[7:0];
    end
  end

  logic rd44_w;
  logic rd45_w;
  assign rd44_w = access_w && !pwrite_i && aligned_w && 6'(idx_w) == cif_pkg::IDX_DAC_STICKY;
  assign rd45_w = access_w && !pwrite_i && aligned_w && 6'(idx_w) == cif_pkg::IDX_REC_FIRST;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic [7:0] pb_prev_q;
  logic [7:0] rec1_prev_q;
  logic [7:0] rec2_prev_q;
  logic [7:0] pb_rise_w;
  logic [7:0] rec1_rise_w;
  logic [7:0] rec2_rise_w;
  logic [7:1] cat_w;
  logic event_w;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pb_prev_q <= cif_pkg::FLAG_RESET;
      rec1_prev_q <= cif_pkg::FLAG_RESET;
      rec2_prev_q <= cif_pkg::FLAG_RESET;
    end else begin
      pb_prev_q <= pb_q;
      rec1_prev_q <= rec1_q;
      rec2_prev_q <= rec2_q;
    end
  end

  // a pulse follows the rising edge of a flag, not its level
  assign pb_rise_w = pb_q & ~pb_prev_q;
  assign rec1_rise_w = rec1_q & ~rec1_prev_q;
  assign rec2_rise_w = rec2_q & ~rec2_prev_q;

  always_comb begin
    cat_w[cif_pkg::EN_HEADSET] = pb_rise_w[cif_pkg::PB_HEADSET] && ctrl_q[cif_pkg::EN_HEADSET];
    cat_w[cif_pkg::EN_BUTTON] = pb_rise_w[cif_pkg::PB_BUTTON] && ctrl_q[cif_pkg::EN_BUTTON];
    cat_w[cif_pkg::EN_DRC] = (pb_rise_w[cif_pkg::PB_DRC_LEFT] || pb_rise_w[cif_pkg::PB_DRC_RIGHT])
                             && ctrl_q[cif_pkg::EN_DRC];
    cat_w[cif_pkg::EN_AGC] = (rec1_rise_w[cif_pkg::RC_NOISE] || rec2_rise_w[cif_pkg::RC_NOISE])
                             && ctrl_q[cif_pkg::EN_AGC];
    cat_w[cif_pkg::EN_SHORT] = pb_rise_w[cif_pkg::PB_SHORT] && ctrl_q[cif_pkg::EN_SHORT];
    cat_w[cif_pkg::EN_ENGINE] = (pb_rise_w[cif_pkg::PB_ENG_STD] || pb_rise_w[cif_pkg::PB_ENG_AUX]
                                 || rec1_rise_w[cif_pkg::RC_ENG_STD] || rec1_rise_w[cif_pkg::RC_ENG_AUX])
                                && ctrl_q[cif_pkg::EN_ENGINE];
    cat_w[cif_pkg::EN_DC] = rec1_rise_w[cif_pkg::RC_DC_AVAIL] && ctrl_q[cif_pkg::EN_DC];
  end

  assign event_w = |cat_w;

  // ----------------------------------------------------------------
  // read acknowledge for repeating pulses
  // ----------------------------------------------------------------
  logic seen44_q;
  logic seen45_q;
  logic acked_w;

  // a new event clears both read acknowledges and wins over a read in the same cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seen44_q <= 1'b0;
      seen45_q <= 1'b0;
    end else if (event_w) begin
      seen44_q <= 1'b0;
      seen45_q <= 1'b0;
    end else begin
      if (rd44_w) begin
        seen44_q <= 1'b1;
      end
      if (rd45_w) begin
        seen45_q <= 1'b1;
      end
    end
  end

  assign acked_w = seen44_q && seen45_q;

  // ----------------------------------------------------------------
  // pulse generator
  // ----------------------------------------------------------------
  localparam logic [cif_pkg::CNT_W-1:0] HIGH_LAST = cif_pkg::CNT_W'(PULSE_CYC - 1);
  localparam logic [cif_pkg::CNT_W-1:0] LOW_LAST = cif_pkg::CNT_W'(PERIOD_CYC - PULSE_CYC - 1);

  cif_pkg::cif_state_t state_q;
  logic [cif_pkg::CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= cif_pkg::CIF_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        cif_pkg::CIF_IDLE: begin
          cnt_q <= '0;
          if (event_w) begin
            state_q <= cif_pkg::CIF_HIGH;
          end
        end
        cif_pkg::CIF_HIGH: begin
          // events during a pulse are merged into it
          if (cnt_q == HIGH_LAST) begin
            cnt_q <= '0;
            if (ctrl_q[cif_pkg::MODE_REPEAT] && !acked_w) begin
              state_q <= cif_pkg::CIF_LOW;
            end else begin
              state_q <= cif_pkg::CIF_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        cif_pkg::CIF_LOW: begin
          if (acked_w || !ctrl_q[cif_pkg::MODE_REPEAT]) begin
            cnt_q <= '0;
            state_q <= cif_pkg::CIF_IDLE;
          end else if (cnt_q == LOW_LAST) begin
            cnt_q <= '0;
            state_q <= cif_pkg::CIF_HIGH;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= cif_pkg::CIF_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  assign irq_line_one_o = (state_q == cif_pkg::CIF_HIGH);
endmodule
`default_nettype wire

// *** testbench/cif_host_model.sv ***
/*
  host side of the first interrupt line: counts pulses and the width
  of the last high and low run. assumes one core clock, active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cif_host_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic irq_i,
  output logic [7:0] pulses_o,
  output logic [7:0] hi_w_o,
  output logic [7:0] lo_w_o
);
  logic [7:0] run_q;
  logic irq_q;
  // widths wrap at 8 bits; only short simulated pulse timings are meaningful
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {run_q, irq_q, pulses_o, hi_w_o, lo_w_o} <= '0;
    end else begin
      irq_q <= irq_i;
      run_q <= (irq_i != irq_q) ? 8'd1 : run_q + 8'd1;
      if (irq_i && !irq_q) begin
        pulses_o <= pulses_o + 8'd1;
        lo_w_o <= run_q;
      end
      if (!irq_i && irq_q) hi_w_o <= run_q;
    end
  end
endmodule
`default_nettype wire

// *** testbench/cif_irq_flags_chk.sv ***
/*
  port checker for cif_irq_flags, bound below.
  assumes an apb master that keeps the protocol.
*/
`timescale 1ns/10ps
`default_nettype none
module cif_irq_flags_chk #(
  parameter int ADDR_W = 8,
  parameter int PULSE_CYC = 4,
  parameter int PERIOD_CYC = 10
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire cif_pkg::cif_src_t src_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic irq_line_one_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] ctrl_q;
  logic [1:0] up_q;
  logic [15:0] hi_q;
  wire logic acc = psel_i && penable_i;
  // read checks wait until the flag pipeline holds post-reset values
  wire logic rd = acc && !pwrite_i && up_q == 2'd3;
  wire logic map = paddr_i inside {8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hc0};
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {ctrl_q, up_q, hi_q} <= '0;
    end else begin
      if (acc && pwrite_i && paddr_i == 8'hc0 && pstrb_i[0]) ctrl_q <= pwdata_i[7:0];
      if (up_q != 2'd3) up_q <= up_q + 2'd1;
      hi_q <= irq_line_one_o ? hi_q + 16'd1 : 16'd0;
    end
  end
  property p_play;
    rd && paddr_i == 8'hb8 |-> prdata_o == {24'h0, $past(src_i[11], 2), 1'b0, $past(src_i[10:5], 2)};
  endproperty
  a_play: assert property (p_play) else $error("playback flags wrong");
  property p_rec1;
    rd && paddr_i == 8'hb4 |-> prdata_o == {25'h0, $past(src_i[4], 2), 1'b0, $past(src_i[2:0], 2), 2'b00};
  endproperty
  a_rec1: assert property (p_rec1) else $error("first record flags wrong");
  property p_rec2;
    rd && paddr_i == 8'hbc |-> prdata_o == {25'h0, $past(src_i[3], 2), 1'b0, $past(src_i[2:0], 2), 2'b00};
  endproperty
  a_rec2: assert property (p_rec2) else $error("second record flags wrong");
  property p_ctrl;
    rd && paddr_i == 8'hc0 |-> prdata_o == {24'h0, $past(ctrl_q)};
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_err;
    acc && !map |-> pslverr_o;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_noerr;
    acc && map |-> !pslverr_o;
  endproperty
  a_noerr: assert property (p_noerr) else $error("mapped access refused");
  property p_width;
    $fell(irq_line_one_o) |-> hi_q == 16'(PULSE_CYC);
  endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_quiet;
    $rose(irq_line_one_o) |-> $past(ctrl_q) != 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse with all enables off");
  c_irq: cover property ($rose(irq_line_one_o));
  c_err: cover property (acc && pslverr_o);
  c_rep: cover property ($fell(irq_line_one_o) && ctrl_q[0]);
endmodule
bind cif_irq_flags cif_irq_flags_chk #(.ADDR_W(ADDR_W), .PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) chk_inst (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .src_i(src_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .irq_line_one_o(irq_line_one_o));
`default_nettype wire

// *** testbench/test_cif_irq_flags.sv ***
/*
  self-checking bench for cif_irq_flags with short pulse timing.
  assumes the package, design, checker and host model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_cif_irq_flags;
  localparam int PULSE = 4;
  localparam int PERIOD = 10;
  localparam logic [11:0] SRCM [7] = '{12'h200, 12'h400, 12'h100, 12'h010, 12'h800, 12'h040, 12'h001};
  localparam int BITN [7] = '{7, 6, 5, 4, 3, 2, 1};
  localparam logic [11:0] PATS [3] = '{12'hfff, 12'ha55, 12'h5aa};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cif_pkg::cif_src_t src = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00, pulses, hi_w, lo_w;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int failures = 0, compares = 0, cyc = 0;
  always #25 clk = ~clk;
  cif_irq_flags #(.ADDR_W(8), .PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) cif_irq_flags_inst (
    .core_clk_i(clk), .reset_n_i(rst_n), .src_i(src), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_line_one_o(irq));
  cif_host_model cif_host_model_inst (.core_clk_i(clk), .reset_n_i(rst_n), .irq_i(irq), .pulses_o(pulses),
    .hi_w_o(hi_w), .lo_w_o(lo_w));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'hb0 + 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'hc4, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'hb9, 32'h0000_00ff);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'hb8, 32'h0000_00ff);
    apb(1'b0, 8'hb8, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_flags();
    logic [11:0] p;
    for (int i = 0; i < 3; i++) begin
      p = PATS[i];
      src <= cif_pkg::cif_src_t'(p);
      apb(1'b0, 8'hb8, 32'h0);
      chk(rd, {24'h0, p[11], 1'b0, p[10:5]});
      apb(1'b0, 8'hb4, 32'h0);
      chk(rd, {25'h0, p[4], 1'b0, p[2:0], 2'b00});
      apb(1'b0, 8'hbc, 32'h0);
      chk(rd, {25'h0, p[3], 1'b0, p[2:0], 2'b00});
    end
  endtask
  task automatic t_mask();
    logic [7:0] p0;
    apb(1'b1, 8'hc0, 32'h0);
    p0 = pulses;
    src <= cif_pkg::cif_src_t'(12'hfff);
    repeat (3 * PERIOD) @(posedge clk);
    chk({24'h0, pulses}, {24'h0, p0});
    for (int i = 0; i < 7; i++) begin
      src <= '0;
      apb(1'b1, 8'hc0, 32'(1) << BITN[i]);
      apb(1'b0, 8'hc0, 32'h0);
      chk(rd, 32'(1) << BITN[i]);
      p0 = pulses;
      src <= cif_pkg::cif_src_t'(SRCM[(i + 1) % 7]);
      repeat (2 * PERIOD) @(posedge clk);
      chk({24'h0, pulses}, {24'h0, p0});
      src <= cif_pkg::cif_src_t'(SRCM[i] | SRCM[(i + 1) % 7]);
      repeat (3 * PERIOD) @(posedge clk);
      src <= '0;
      repeat (2 * PERIOD) @(posedge clk);
      chk({24'h0, pulses}, {24'h0, p0 + 8'd1});
      chk({24'h0, hi_w}, 32'(PULSE));
    end
  endtask
  task automatic t_repeat();
    logic [7:0] p0;
    apb(1'b1, 8'hc0, 32'h0000_0009);
    p0 = pulses;
    src <= cif_pkg::cif_src_t'(12'h800);
    repeat (4 * PERIOD) @(posedge clk);
    chk({31'h0, (pulses - p0) > 8'd2}, 32'h1);
    chk({24'h0, lo_w}, 32'(PERIOD - PULSE));
    // one acknowledging read alone must not stop the train
    apb(1'b0, 8'hb0, 32'h0);
    p0 = pulses;
    repeat (2 * PERIOD) @(posedge clk);
    chk({31'h0, pulses != p0}, 32'h1);
    apb(1'b0, 8'hb4, 32'h0);
    repeat (2 * PERIOD) @(posedge clk);
    p0 = pulses;
    repeat (3 * PERIOD) @(posedge clk);
    chk({24'h0, pulses}, {24'h0, p0});
    src <= '0;
    apb(1'b1, 8'hc0, 32'h0);
  endtask
  task automatic complete_run();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_mask();
    t_repeat();
    complete_run();
  end
endmodule
`default_nettype wire
